// ---- src/svw_device.sv ----
// Supervisor end: reset sequencing, watchdog, converter update and serial slave.
// Assumes every pin and link signal is asynchronous to pclk; link level from svw_if.
`timescale 1ns/1ns
module svw_device
   import svw_pkg::*;
#(
   parameter int HOLD_CYC = ms_cyc(T_HOLD_MS),
   parameter int OSC_CYC  = ms_cyc(T_OSC_MS),
   parameter int WD1_CYC  = ms_cyc(T_WD1_MS),
   parameter int WD2_CYC  = ms_cyc(T_WD2_MS),
   parameter int WD3_CYC  = ms_cyc(T_WD3_MS),
   parameter int ADC_CYC  = ms_cyc(T_ADC_MS),
   parameter int CU_CYC   = us_cyc(T_CU_US)
) (
   input  wire logic       pclk,
   input  wire logic       presetn,
   svw_if.dev              link,
   input  wire logic       supply_ok,
   input  wire logic       rst_line,
   output logic            rst_out,
   output logic            rst_oe_n,
   input  wire logic [7:0] analog_input_0,
   input  wire logic [7:0] analog_input_1,
   input  wire logic [7:0] analog_input_2
);

   typedef enum logic [2:0] {S_PF, S_HOLD, S_SETTLE, S_WREL, S_RUN} svw_sup_t;

   typedef struct packed {
      svw_sup_t        st;
      logic [CW-1:0]   tmr;
      logic [CW-1:0]   wd;
      logic [1:0]      sup_s;
      logic [1:0]      line_s;
      logic [1:0]      kick_s;
      logic [1:0]      cs_s;
      logic [1:0]      sclk_s;
      logic [1:0]      io_s;
      logic            line_q;
      logic            kick_q;
      logic            sclk_q;
      logic [2:0][7:0] ain_a;
      logic [2:0][7:0] ain_b;
      logic [7:0]      ctrl;
      logic [7:0]      wdog;
      logic [7:0]      adc;
      logic [CW-1:0]   acnt;
      logic            cmd_ph;
      logic            rd;
      logic [2:0]      bcnt;
      logic [7:0]      sh;
      logic [7:0]      tx;
      logic [6:0]      addr;
      logic            dout;
      logic            doe_n;
   } svw_dev_t;

   localparam svw_dev_t DEV_RST = '{
      st:      S_PF,
      ctrl:    CTRL_RST,
      wdog:    WDOG_RST,
      acnt:    CW'(CU_CYC),
      cmd_ph:  1'b1,
      doe_n:   1'b1,
      default: '0
   };

   svw_dev_t   s;
   svw_dev_t   next_s;
   logic [7:0] sin;
   logic       sup;
   logic       line;
   logic       line_fall;
   logic       kick_fall;
   logic       cs;
   logic       rise;
   logic       fall;
   logic [1:0] ch;
   logic [1:0] td;
   logic       cu;
   logic       lock;

   // Sync outputs only; first stages feed nothing but the second
   assign sup       = s.sup_s[1];
   assign line      = s.line_s[1];
   assign line_fall = s.line_q & ~line;
   assign kick_fall = s.kick_q & ~s.kick_s[1];
   assign cs        = s.cs_s[1];
   assign rise      = s.sclk_s[1] & ~s.sclk_q;
   assign fall      = ~s.sclk_s[1] & s.sclk_q;
   assign ch        = s.ctrl[CTRL_CH +: 2];
   assign td        = s.wdog[WD_TD +: 2];
   assign cu        = (ch != CH_OFF) && (s.acnt <= CW'(CU_CYC));
   assign lock      = cs && !s.cmd_ph && s.rd && (s.addr == A_ADC);

   function automatic logic [CW-1:0] wd_lim(input logic [1:0] code);
      case (code)
         TD_250:  return CW'(WD1_CYC);
         TD_500:  return CW'(WD2_CYC);
         default: return CW'(WD3_CYC);
      endcase
   endfunction

   function automatic logic [7:0] reg_rd(input logic [6:0] a, input svw_dev_t d, input logic c);
      case (a)
         A_CTRL:  return d.ctrl;
         A_STAT:  return 8'(c) << STAT_CU;
         A_WDOG:  return d.wdog;
         A_ADC:   return d.adc;
         default: return 8'h00;
      endcase
   endfunction

   function automatic logic [CW-1:0] hold_ld(input logic extra);
      return CW'(HOLD_CYC - 1) + (extra ? CW'(OSC_CYC) : CW'(0));
   endfunction

   always_comb begin
      next_s = s;
      sin = {s.io_s[1], s.sh[7:1]};
      next_s.sup_s  = {s.sup_s[0], supply_ok};
      next_s.line_s = {s.line_s[0], rst_line};
      next_s.kick_s = {s.kick_s[0], link.kick_n};
      next_s.cs_s   = {s.cs_s[0], link.cs};
      next_s.sclk_s = {s.sclk_s[0], link.sclk};
      next_s.io_s   = {s.io_s[0], link.io};
      next_s.ain_a  = {analog_input_2, analog_input_1, analog_input_0};
      next_s.ain_b  = s.ain_a;
      next_s.line_q = line;
      next_s.kick_q = s.kick_s[1];
      next_s.sclk_q = s.sclk_s[1];

      // Reset sequencer
      case (s.st)
         S_PF: begin
            if (sup) begin
               next_s.st  = S_HOLD;
               next_s.tmr = hold_ld(s.ctrl[CTRL_OSC]);
            end
         end
         S_HOLD: begin
            if (s.tmr == '0) begin
               // Release and let the line settle before judging it
               next_s.st  = S_SETTLE;
               next_s.tmr = CW'(SETTLE_CYC);
            end else begin
               next_s.tmr = s.tmr - CW'(1);
            end
         end
         S_SETTLE: begin
            if (s.tmr == '0) begin
               next_s.st = line ? S_RUN : S_WREL;
               next_s.wd = '0;
            end else begin
               next_s.tmr = s.tmr - CW'(1);
            end
         end
         S_WREL: begin
            if (line) begin
               next_s.st  = S_HOLD;
               next_s.tmr = hold_ld(1'b0);
            end
         end
         S_RUN: begin
            if (line_fall) begin
               next_s.st  = S_HOLD;
               next_s.tmr = hold_ld(1'b0);
            end else if (td != TD_OFF && s.wd >= wd_lim(td) - CW'(1)) begin
               next_s.st  = S_HOLD;
               next_s.tmr = hold_ld(1'b0);
            end else if (kick_fall || td == TD_OFF) begin
               next_s.wd = '0;
            end else begin
               next_s.wd = s.wd + CW'(1);
            end
         end
         default: begin
            next_s.st = S_PF;
         end
      endcase
      if (!sup) begin
         next_s.st = S_PF;
      end

      // Converter update timing; off keeps the counter primed for turn-on
      if (ch == CH_OFF) begin
         next_s.acnt = CW'(CU_CYC);
      end else if (s.acnt != '0) begin
         next_s.acnt = s.acnt - CW'(1);
      end else if (!lock) begin
         next_s.adc  = s.ain_b[ch - 2'd1];
         next_s.acnt = CW'(ADC_CYC - 1);
      end

      // Serial slave
      if (!cs) begin
         next_s.cmd_ph = 1'b1;
         next_s.rd     = 1'b0;
         next_s.bcnt   = '0;
         next_s.doe_n  = 1'b1;
      end else begin
         if (rise) begin
            next_s.bcnt = s.bcnt + 3'd1;
            if (s.cmd_ph || !s.rd) begin
               next_s.sh = sin;
            end
            if (s.bcnt == 3'd7) begin
               if (s.cmd_ph) begin
                  next_s.cmd_ph = 1'b0;
                  next_s.rd     = ~sin[CMD_DIR];
                  next_s.addr   = sin[6:0];
                  next_s.tx     = reg_rd(sin[6:0], s, cu);
               end else begin
                  next_s.addr = next_addr(s.addr);
                  next_s.tx   = reg_rd(next_addr(s.addr), s, cu);
                  if (!s.rd && s.addr == A_CTRL) begin
                     next_s.ctrl = sin & CTRL_MASK;
                  end
                  if (!s.rd && s.addr == A_WDOG) begin
                     next_s.wdog = sin & WDOG_MASK;
                  end
               end
            end
         end
         if (fall && s.rd && !s.cmd_ph) begin
            next_s.dout  = s.tx[s.bcnt];
            next_s.doe_n = 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= DEV_RST;
      end else begin
         s <= next_s;
      end
   end

   // Open drain: only ever pulls low
   assign rst_out       = 1'b0;
   assign rst_oe_n      = !(s.st == S_PF || s.st == S_HOLD);
   assign link.dev_dout = s.dout;
   assign link.dev_oe_n = s.doe_n;

endmodule // svw_device

// ---- src/svw_host.sv ----
// Host end: APB slave that runs three-wire transfers and watchdog kicks.
// Assumes an APB master on pclk; the link clock is divided down from pclk.
`timescale 1ns/1ns
module svw_host
   import svw_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   svw_if.host              link
);

   typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_END} svw_hst_t;

   typedef struct packed {
      svw_hst_t    st;
      logic [3:0]  ph;
      logic [5:0]  bitn;
      logic [5:0]  last;
      logic        rd;
      logic [39:0] obits;
      logic [31:0] wdat;
      logic [31:0] rdat;
      logic [31:0] prd;
      logic [1:0]  io_s;
      logic [3:0]  kcnt;
      logic        kick_n;
      logic        cs;
      logic        sclk;
      logic        dout;
      logic        doe_n;
   } svw_host_t;

   localparam svw_host_t HOST_RST = '{st: H_IDLE, kick_n: 1'b1, doe_n: 1'b1, default: '0};

   svw_host_t s;
   svw_host_t next_s;
   logic      wr;
   logic      busy;

   assign wr   = psel & penable & pwrite;
   assign busy = (s.st != H_IDLE);

   always_comb begin
      next_s = s;
      next_s.io_s = {s.io_s[0], link.io};
      if (psel && !penable) begin
         case (paddr)
            H_WDATA: next_s.prd = s.wdat;
            H_RDATA: next_s.prd = s.rdat;
            H_STAT:  next_s.prd = 32'(busy);
            default: next_s.prd = 32'h0;
         endcase
      end
      if (wr && paddr == H_WDATA) begin
         next_s.wdat = pwdata;
      end
      // Kick pulse; software must pace these inside the shortest timeout
      if (s.kcnt != 4'h0) begin
         next_s.kcnt = s.kcnt - 4'h1;
      end else begin
         next_s.kick_n = 1'b1;
      end
      if (wr && paddr == H_KICK) begin
         next_s.kcnt   = KICK_CYC;
         next_s.kick_n = 1'b0;
      end

      case (s.st)
         H_IDLE: begin
            // Orders arriving mid-transfer are dropped, not queued
            if (wr && paddr == H_CMD) begin
               next_s.st    = H_LOW;
               next_s.cs    = 1'b1;
               next_s.ph    = HALF_CYC - 4'h1;
               next_s.bitn  = '0;
               next_s.last  = {3'(pwdata[CMD_NB +: 2]) + 3'd1, 3'b111};
               next_s.rd    = ~pwdata[CMD_DIR];
               next_s.obits = {s.wdat, pwdata[7:0]};
               next_s.dout  = pwdata[0];
               next_s.doe_n = 1'b0;
               next_s.rdat  = '0;
            end
         end
         H_LOW: begin
            if (s.ph != 4'h0) begin
               next_s.ph = s.ph - 4'h1;
            end else begin
               if (s.rd && s.bitn >= 6'd8) begin
                  next_s.rdat[5'(s.bitn - 6'd8)] = s.io_s[1];
               end
               next_s.sclk = 1'b1;
               next_s.st   = H_HIGH;
               next_s.ph   = HALF_CYC - 4'h1;
            end
         end
         H_HIGH: begin
            if (s.ph != 4'h0) begin
               next_s.ph = s.ph - 4'h1;
            end else begin
               next_s.sclk = 1'b0;
               next_s.ph   = HALF_CYC - 4'h1;
               if (s.bitn == s.last) begin
                  next_s.st    = H_END;
                  next_s.doe_n = 1'b1;
               end else begin
                  next_s.st    = H_LOW;
                  next_s.bitn  = s.bitn + 6'd1;
                  next_s.obits = s.obits >> 1;
                  next_s.dout  = s.obits[1];
                  next_s.doe_n = s.rd && s.bitn >= 6'd7;
               end
            end
         end
         H_END: begin
            if (s.ph != 4'h0) begin
               next_s.ph = s.ph - 4'h1;
            end else begin
               next_s.cs = 1'b0;
               next_s.st = H_IDLE;
            end
         end
         default: begin
            next_s.st = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= HOST_RST;
      end else begin
         s <= next_s;
      end
   end

   assign prdata         = s.prd;
   assign pready         = 1'b1;
   assign pslverr        = 1'b0;
   assign link.cs        = s.cs;
   assign link.sclk      = s.sclk;
   assign link.kick_n    = s.kick_n;
   assign link.host_dout = s.dout;
   assign link.host_oe_n = s.doe_n;

endmodule // svw_host

// ---- src/svw_if.sv ----
// Three-wire link plus watchdog kick between host and supervisor.
// The shared data wire idles high when neither end drives it.
`timescale 1ns/1ns
interface svw_if;
   logic cs;
   logic sclk;
   logic kick_n;
   logic host_dout;
   logic host_oe_n;
   logic dev_dout;
   logic dev_oe_n;
   logic io;

   assign io = !dev_oe_n ? dev_dout : (!host_oe_n ? host_dout : 1'b1);

   modport dev (input cs, input sclk, input kick_n, input io, output dev_dout, output dev_oe_n);
   modport host (output cs, output sclk, output kick_n, output host_dout, output host_oe_n, input io);
endinterface

// ---- src/svw_pkg.sv ----
// Constants shared by both ends of the supervisor serial link.
// Assumes both ends run on a 125 MHz pclk.
// What this block does
// - Bad supply forces reset active at once
// - Hold reset 250 ms after supply recovers
// - Oscillator-disable adds oscillator start time to hold
// - Idle line falling edge: pull low 250 ms
// - Still low afterwards: wait release, pull 250 ms
// - Watchdog starts timing when reset releases
// - Delay code: off, 250, 500, 1000 ms
// - Watchdog enabled at 1000 ms after power-up
// - Kick falling edge restarts full watchdog period
// - Watchdog expiry pulls reset for 250 ms
// - Host kicks within the shortest timeout
// - Result is unsigned 8-bit code, 00h-FFh
// - Turning converter on updates within 488 us
// - Update every 10 ms; channel change next slot
// - Update flag high within 488 us window
// - Host polls update flag before reading result
// - Result read blocks updates until done or deselect
// - Chip select frames transfer; low tri-states data
// - Write bits sampled rising, read bits after falling
// - Command and data shifted LSB first
// - First byte is command; top bit 0 reads
// - Address increments per byte, 0Eh wraps 00h
// - Channel code: off, input 0, 1, 2
package svw_pkg;
   localparam int CLK_MHZ     = 125;
   localparam int CLK_KHZ     = CLK_MHZ * 1000;
   localparam int CW          = 28;
   localparam int T_HOLD_MS   = 250;
   localparam int T_OSC_MS    = 2;
   localparam int T_WD1_MS    = 250;
   localparam int T_WD2_MS    = 500;
   localparam int T_WD3_MS    = 1000;
   localparam int T_ADC_MS    = 10;
   localparam int T_CU_US     = 488;
   localparam int SETTLE_CYC  = 4;

   localparam logic [6:0] A_CTRL = 7'h0B;
   localparam logic [6:0] A_STAT = 7'h0C;
   localparam logic [6:0] A_WDOG = 7'h0D;
   localparam logic [6:0] A_ADC  = 7'h0E;
   localparam logic [6:0] A_LAST = 7'h0E;
   localparam int CTRL_OSC = 7;
   localparam int CTRL_CH  = 4;
   localparam int STAT_CU  = 7;
   localparam int CMD_DIR  = 7;
   localparam int WD_TD    = 0;
   localparam logic [7:0] CTRL_MASK = 8'hB0;
   localparam logic [7:0] WDOG_MASK = 8'h03;
   localparam logic [7:0] CTRL_RST  = 8'h80;
   localparam logic [7:0] WDOG_RST  = 8'h03;
   localparam logic [1:0] TD_OFF    = 2'h0;
   localparam logic [1:0] TD_250    = 2'h1;
   localparam logic [1:0] TD_500    = 2'h2;
   localparam logic [1:0] CH_OFF    = 2'h0;

   localparam logic [3:0] HALF_CYC  = 4'h8;
   localparam logic [3:0] KICK_CYC  = 4'h8;
   localparam logic [11:0] H_CMD    = 12'h000;
   localparam logic [11:0] H_WDATA  = 12'h004;
   localparam logic [11:0] H_RDATA  = 12'h008;
   localparam logic [11:0] H_STAT   = 12'h00C;
   localparam logic [11:0] H_KICK   = 12'h010;
   localparam int CMD_NB = 8;

   function automatic int ms_cyc(input int ms);
      return ms * CLK_KHZ;
   endfunction

   function automatic int us_cyc(input int us);
      return us * CLK_MHZ;
   endfunction

   function automatic logic [6:0] next_addr(input logic [6:0] a);
      return (a >= A_LAST) ? 7'h00 : a + 7'h01;
   endfunction
endpackage

// ---- verification/svw_monitor.sv ----
// Concurrent checks on the link, kick line and reset pin.
// Assumes tb instantiates it beside svw_if; everything on pclk.
`timescale 1ns/1ns
module svw_monitor #(
   parameter int HOLD_CYC = 200
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cs,
   input wire logic sclk,
   input wire logic kick_n,
   input wire logic host_oe_n,
   input wire logic dev_dout,
   input wire logic dev_oe_n,
   input wire logic io,
   input wire logic supply_ok,
   input wire logic rst_oe_n
);
   logic [15:0] low_cnt;

   // Saturates so a stuck reset cannot wrap into a short count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) low_cnt <= 16'h0000;
      else if (rst_oe_n) low_cnt <= 16'h0000;
      else if (low_cnt != 16'hFFFF) low_cnt <= low_cnt + 16'h0001;
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_supply_pull: assert property (!supply_ok |-> ##[0:3] !rst_oe_n)
      else $error("reset not pulled on supply loss");
   a_hold_length: assert property ($rose(rst_oe_n) |-> low_cnt >= 16'(HOLD_CYC))
      else $error("reset hold too short");
   a_cs_release_io: assert property ($fell(cs) |-> ##[1:4] dev_oe_n)
      else $error("data pin still driven after deselect");
   a_sclk_idle: assert property (!cs |-> !sclk)
      else $error("serial clock moves outside a frame");
   a_no_fight: assert property (!(!dev_oe_n && !host_oe_n))
      else $error("both ends drive the data wire");
   a_dev_change_low: assert property (!dev_oe_n && $changed(dev_dout) |-> !sclk)
      else $error("read bit changed while clock high");
   a_io_stable_rise: assert property ($rose(sclk) |-> $stable(io))
      else $error("data changed at rising clock");
   a_sclk_high_len: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
      else $error("clock high phase wrong length");
   // Kick counter reload plus its drain keeps the line low for nine samples
   a_kick_pulse: assert property ($fell(kick_n) |-> !kick_n [*8] ##1 !kick_n ##1 kick_n)
      else $error("kick pulse wrong length");

   c_frame_end: cover property ($fell(cs));
   c_dev_reads: cover property ($fell(dev_oe_n));
   c_reset_done: cover property ($rose(rst_oe_n));
   c_kick_seen: cover property ($fell(kick_n));
endmodule // svw_monitor

// ---- verification/tb.sv ----
// Bench: APB drives the host end, which talks to the supervisor end.
// Assumes the package, interface, both ends and svw_monitor compile first.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin err_count++; \
   $display("mismatch %s exp %0h got %0h", nm, ex, got); end end
module tb;
   import svw_pkg::*;
   localparam int HOLD   = 200;
   localparam int OSC    = 20;
   localparam int ADC    = 400;
   localparam int CU     = 100;
   localparam int WD [4] = '{0, 300, 600, 1200};
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, chk;
   logic        supply_ok, button, rst_out, rst_oe_n, rst_line, seen;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0]  ain [3];
   logic [31:0] exp_q [$];
   int          err_count, cmp_count, seed, c, n;

   svw_if link_if ();
   // Open-drain wire: device pull or pressed button
   assign rst_line = rst_oe_n & ~button;
   svw_device #(.HOLD_CYC(HOLD), .OSC_CYC(OSC), .WD1_CYC(WD[1]), .WD2_CYC(WD[2]), .WD3_CYC(WD[3]),
      .ADC_CYC(ADC), .CU_CYC(CU)) svw_device_inst (.pclk(pclk), .presetn(presetn), .link(link_if),
      .supply_ok(supply_ok), .rst_line(rst_line), .rst_out(rst_out), .rst_oe_n(rst_oe_n),
      .analog_input_0(ain[0]), .analog_input_1(ain[1]), .analog_input_2(ain[2]));
   svw_host svw_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_if));
   svw_monitor #(.HOLD_CYC(HOLD)) svw_monitor_inst (.pclk(pclk), .presetn(presetn), .cs(link_if.cs),
      .sclk(link_if.sclk), .kick_n(link_if.kick_n), .host_oe_n(link_if.host_oe_n),
      .dev_dout(link_if.dev_dout), .dev_oe_n(link_if.dev_oe_n), .io(link_if.io),
      .supply_ok(supply_ok), .rst_oe_n(rst_oe_n));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // Read results are compared against the oldest note
   always @(posedge pclk) begin : scb
      logic [31:0] e;
      if (psel && penable && pready && chk) begin
         e = exp_q.pop_front();
         `CHK("rdata", e, prdata)
         `CHK("pslverr", 1'b0, pslverr)
      end
   end

   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic ck);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      chk <= ck;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      chk <= 1'b0;
   endtask

   task automatic kick();
      apb(1'b1, H_KICK, 32'h0, 1'b0);
   endtask

   task automatic xfer(input logic [7:0] cmd, input int nb, input logic [31:0] wd);
      int n;
      n = 0;
      apb(1'b1, H_WDATA, wd, 1'b0);
      apb(1'b1, H_CMD, {22'h0, 2'(nb - 1), cmd}, 1'b0);
      do begin
         apb(1'b0, H_STAT, 32'h0, 1'b0);
         n++;
      end while (prdata[0] !== 1'b0 && n < 3000);
   endtask

   task automatic rd(input logic [6:0] a, input int nb, input logic [31:0] e);
      xfer({1'b0, a}, nb, 32'h0);
      exp_q.push_back(e);
      apb(1'b0, H_RDATA, 32'h0, 1'b1);
   endtask

   task automatic wait_oe(input logic v, input int lim);
      c = 0;
      while (rst_oe_n !== v && c < lim) begin
         @(posedge pclk);
         c++;
      end
   endtask

   task automatic hold_ok(input int base);
      wait_oe(1'b1, 3000);
      `CHK("hold", 1'b1, c + 4 >= base && c <= base + 12)
   endtask

   initial begin
      #320000;
      err_count++;
      report_and_stop();
   end

   initial begin
      seed = 32'hA818;
      {presetn, psel, penable, pwrite, chk, supply_ok, button} = 7'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      foreach (ain[i]) ain[i] = 8'($random(seed));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      supply_ok <= 1'b1;
      hold_ok(HOLD + OSC);
      rd(A_WDOG, 1, 32'h03);
      kick();
      rd(A_CTRL, 4, 32'h0003_0080);
      kick();
      xfer({1'b1, 7'h0A}, 4, 32'h00FF_80FF);
      rd(A_WDOG, 1, 32'h0);
      exp_q.push_back(32'h0);
      apb(1'b0, 12'h014, 32'h0, 1'b1);
      wait_oe(1'b0, 1500);
      `CHK("wd off", 1500, c)
      // Longest first, so each rewrite lands before the old period ends
      for (int k = 3; k > 0; k--) begin
         kick();
         xfer({1'b1, A_WDOG}, 1, 32'(k));
         kick();
         repeat (WD[1] / 2) @(posedge pclk);
         kick();
         wait_oe(1'b0, 3000);
         `CHK("wd period", 1'b1, c + 2 >= WD[k] && c <= WD[k] + 12)
         hold_ok(HOLD);
      end
      kick();
      xfer({1'b1, A_WDOG}, 1, 32'h0);
      button <= 1'b1;
      wait_oe(1'b0, 8);
      `CHK("button pull", 1'b0, rst_oe_n)
      `CHK("rst_out", 1'b0, rst_out)
      button <= 1'b0;
      hold_ok(HOLD);
      repeat (20) @(posedge pclk);
      button <= 1'b1;
      wait_oe(1'b0, 8);
      hold_ok(HOLD);
      repeat (40) @(posedge pclk);
      `CHK("wait release", 1'b1, rst_oe_n)
      button <= 1'b0;
      wait_oe(1'b0, 8);
      `CHK("pull again", 1'b0, rst_oe_n)
      hold_ok(HOLD);
      for (int ch = 1; ch < 4; ch++) begin
         xfer({1'b1, A_CTRL}, 1, {24'h0, 2'b10, 2'(ch), 4'h0});
         if (ch > 1) repeat (ADC + 20) @(posedge pclk);
         // Let a flagged update pass first so the result read is settled
         seen = 1'b0;
         n = 0;
         do begin
            xfer({1'b0, A_STAT}, 1, 32'h0);
            apb(1'b0, H_RDATA, 32'h0, 1'b0);
            seen |= prdata[STAT_CU];
            n++;
         end while (!(seen && !prdata[STAT_CU]) && n < 16);
         `CHK("cu seen", 1'b1, seen)
         `CHK("cu clear", 1'b0, prdata[STAT_CU])
         rd(A_ADC, 1, {24'h0, ain[ch - 1]});
      end
      // Oscillator left running, so this hold has no start-up time added
      xfer({1'b1, A_CTRL}, 1, 32'h0);
      supply_ok <= 1'b0;
      wait_oe(1'b0, 4);
      `CHK("supply fail", 1'b0, rst_oe_n)
      repeat (10) @(posedge pclk);
      supply_ok <= 1'b1;
      hold_ok(HOLD);
      report_and_stop();
   end
endmodule // tb
